// file: dcea_defines.vh
`ifndef DCEA_DEFINES_VH
`define DCEA_DEFINES_VH

// Register byte offsets
`define DCEA_OFF_ENABLE_SET     12'h028
`define DCEA_OFF_DISABLE        12'h02c
`define DCEA_OFF_ALT_SELECT     12'h030
`define DCEA_OFF_PRI_SELECT     12'h034
`define DCEA_OFF_IRQ_STATUS     12'h050
`define DCEA_OFF_IRQ_MASK       12'h054

// Reset values
`define DCEA_RST_ENABLE         14'h0000
`define DCEA_RST_ALT            14'h0000
`define DCEA_RST_MASK           3'h0

// Cycle type encodings of the channel configuration word
`define DCEA_CYC_STOP           3'h0
`define DCEA_CYC_PINGPONG       3'h3
`define DCEA_CYC_MEM_SG_PRI     3'h4
`define DCEA_CYC_MEM_SG_ALT     3'h5
`define DCEA_CYC_PER_SG_PRI     3'h6
`define DCEA_CYC_PER_SG_ALT     3'h7

// Interrupt status bit positions
`define DCEA_IRQ_DONE_BIT       0
`define DCEA_IRQ_STOP_BIT       1
`define DCEA_IRQ_ERR_BIT        2

// Scatter-gather primary task length in transfers
`define DCEA_SG_PRI_XFERS       4

// AXI responses
`define DCEA_RESP_OKAY          2'h0
`define DCEA_RESP_SLVERR        2'h2

`endif

// file: dcea_channel_ctrl.v
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "dcea_defines.vh"

// Functional notes
// - Disable vector one-bits disable channels
// - Reserved upper bits read as zero
// - Unimplemented channel bits writes ignored
// - Auto-disable on done, stop config, error
// - Select vector reads primary zero, alternate one
// - Alternate select one-bits choose alternate
// - Primary select one-bits choose primary
// - Scatter-gather toggles after four primary transfers
// - Ping-pong toggles after primary transfers
// - Alternate task completion toggles select bit
// - Enable vector reads status, ones enable
module dcea_channel_ctrl #(
    parameter NUM_CH = 14
) (
    input  wire        i_clk,
    input  wire        i_reset,
    // AXI4-Lite slave
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Transfer engine events, one-cycle pulses
    input  wire        i_evt_valid,
    input  wire [3:0]  i_evt_channel,
    input  wire        i_evt_cfg_fetch,
    input  wire [2:0]  i_evt_cycle_type,
    input  wire        i_evt_task_done,
    input  wire        i_evt_cycle_done,
    input  wire        i_evt_bus_error,
    // Channel state towards the engine
    output reg  [13:0] o_channel_enable,
    output reg  [13:0] o_alt_select,
    output reg         o_irq
);

    localparam [13:0] IMPL_MASK = (NUM_CH >= 14) ? 14'h3fff : ((14'h0001 << NUM_CH) - 14'h0001);

    reg  [13:0] enable_reg;
    reg  [13:0] enable_next;
    reg  [13:0] alt_reg;
    reg  [13:0] alt_next;
    reg  [2:0]  irq_status_reg;
    reg  [2:0]  irq_status_next;
    reg  [2:0]  irq_mask_reg;
    reg  [11:0] awaddr_reg;
    reg         aw_held_reg;
    reg  [31:0] wdata_reg;
    reg  [3:0]  wstrb_reg;
    reg         w_held_reg;
    reg  [2:0]  sg_count_reg [0:13];
    reg  [2:0]  sg_count_next [0:13];

    wire        wr_fire = aw_held_reg && w_held_reg && !o_bvalid;
    wire        rd_fire = o_arready && i_arvalid;
    wire [13:0] wr_bits = wdata_reg[13:0] & IMPL_MASK;
    wire        wr_full = wstrb_reg[0] && wstrb_reg[1];
    wire        rd_status = rd_fire && (i_araddr == `DCEA_OFF_IRQ_STATUS);
    // Mask takes effect on the interrupt in the cycle it is written
    wire [2:0]  irq_mask_next = (wr_fire && wr_full && (awaddr_reg == `DCEA_OFF_IRQ_MASK)) ?
                                wdata_reg[2:0] : irq_mask_reg;
    localparam [31:0] SG_LAST_W = `DCEA_SG_PRI_XFERS - 1;

    // Events on absent channels touch neither channel state nor status
    wire        ch_ok = i_evt_valid && (i_evt_channel < NUM_CH);
    wire [13:0] ch_onehot = ch_ok ? (14'h0001 << i_evt_channel) : 14'h0000;
    wire        is_pp = (i_evt_cycle_type == `DCEA_CYC_PINGPONG);
    wire        is_sg_pri = (i_evt_cycle_type == `DCEA_CYC_MEM_SG_PRI) ||
                            (i_evt_cycle_type == `DCEA_CYC_PER_SG_PRI);
    wire        is_sg_alt = (i_evt_cycle_type == `DCEA_CYC_MEM_SG_ALT) ||
                            (i_evt_cycle_type == `DCEA_CYC_PER_SG_ALT);
    wire        stop_cfg = i_evt_cfg_fetch && (i_evt_cycle_type == `DCEA_CYC_STOP);
    wire        auto_off = i_evt_cycle_done || stop_cfg || i_evt_bus_error;

    integer c;
    integer s;

    // Channel state: software writes first, then hardware events, so an
    // engine-side disable or toggle in the same cycle is never lost.
    always @* begin
        enable_next = enable_reg;
        alt_next = alt_reg;
        for (c = 0; c < 14; c = c + 1) begin
            sg_count_next[c] = sg_count_reg[c];
        end
        if (wr_fire && wr_full) begin
            case (awaddr_reg)
                `DCEA_OFF_ENABLE_SET: enable_next = enable_reg | wr_bits;
                `DCEA_OFF_DISABLE:    enable_next = enable_reg & ~wr_bits;
                `DCEA_OFF_ALT_SELECT: alt_next = alt_reg | wr_bits;
                `DCEA_OFF_PRI_SELECT: alt_next = alt_reg & ~wr_bits;
                default: enable_next = enable_next;
            endcase
        end
        for (c = 0; c < 14; c = c + 1) begin
            if (ch_onehot[c]) begin
                if (auto_off) begin
                    enable_next[c] = 1'b0;
                end
                if (i_evt_task_done && !alt_reg[c] && is_sg_pri) begin
                    if (sg_count_reg[c] == SG_LAST_W[2:0]) begin
                        alt_next[c] = ~alt_reg[c];
                        sg_count_next[c] = 3'h0;
                    end else begin
                        sg_count_next[c] = sg_count_reg[c] + 3'h1;
                    end
                end else if (i_evt_task_done && !alt_reg[c] && is_pp) begin
                    alt_next[c] = ~alt_reg[c];
                end else if (i_evt_task_done && alt_reg[c] && (is_pp || is_sg_alt)) begin
                    alt_next[c] = ~alt_reg[c];
                    sg_count_next[c] = 3'h0;
                end
            end
        end
    end

    // Interrupt: set beats the read-clear of the same cycle
    always @* begin
        irq_status_next = rd_status ? 3'h0 : irq_status_reg;
        if (ch_ok && i_evt_cycle_done) begin
            irq_status_next[`DCEA_IRQ_DONE_BIT] = 1'b1;
        end
        if (ch_ok && stop_cfg) begin
            irq_status_next[`DCEA_IRQ_STOP_BIT] = 1'b1;
        end
        if (ch_ok && i_evt_bus_error) begin
            irq_status_next[`DCEA_IRQ_ERR_BIT] = 1'b1;
        end
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            enable_reg <= `DCEA_RST_ENABLE;
            alt_reg <= `DCEA_RST_ALT;
            irq_status_reg <= 3'h0;
            irq_mask_reg <= `DCEA_RST_MASK;
            o_channel_enable <= `DCEA_RST_ENABLE;
            o_alt_select <= `DCEA_RST_ALT;
            o_irq <= 1'b0;
            for (s = 0; s < 14; s = s + 1) begin
                sg_count_reg[s] <= 3'h0;
            end
        end else begin
            enable_reg <= enable_next;
            alt_reg <= alt_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            o_channel_enable <= enable_next;
            o_alt_select <= alt_next;
            o_irq <= |(irq_status_next & irq_mask_next);
            for (s = 0; s < 14; s = s + 1) begin
                sg_count_reg[s] <= sg_count_next[s];
            end
        end
    end

    // Write channels: address and data latched in either order
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= `DCEA_RESP_OKAY;
        end else begin
            if (o_awready && i_awvalid) begin
                awaddr_reg <= i_awaddr;
                aw_held_reg <= 1'b1;
                o_awready <= 1'b0;
            end
            if (o_wready && i_wvalid) begin
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
                w_held_reg <= 1'b1;
                o_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_bvalid <= 1'b1;
                case (awaddr_reg)
                    `DCEA_OFF_ENABLE_SET,
                    `DCEA_OFF_DISABLE,
                    `DCEA_OFF_ALT_SELECT,
                    `DCEA_OFF_PRI_SELECT,
                    `DCEA_OFF_IRQ_MASK: o_bresp <= `DCEA_RESP_OKAY;
                    default:            o_bresp <= `DCEA_RESP_SLVERR;
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // Read channel; write-only vectors read zero
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= `DCEA_RESP_OKAY;
        end else begin
            if (rd_fire) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rresp <= `DCEA_RESP_OKAY;
                case (i_araddr)
                    `DCEA_OFF_ENABLE_SET: o_rdata <= {18'h0, enable_reg};
                    `DCEA_OFF_ALT_SELECT: o_rdata <= {18'h0, alt_reg};
                    `DCEA_OFF_DISABLE,
                    `DCEA_OFF_PRI_SELECT: o_rdata <= 32'h00000000;
                    `DCEA_OFF_IRQ_STATUS: o_rdata <= {29'h0, irq_status_reg};
                    `DCEA_OFF_IRQ_MASK:   o_rdata <= {29'h0, irq_mask_reg};
                    default: begin
                        o_rdata <= 32'h00000000;
                        o_rresp <= `DCEA_RESP_SLVERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

endmodule

// file: dcea_props.sv
`timescale 1ns/1ps
`include "dcea_defines.vh"
module dcea_props (
    input wire        i_clk,
    input wire        i_reset,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire [1:0]  o_bresp,
    input wire        o_rvalid,
    input wire        i_rready,
    input wire [31:0] o_rdata,
    input wire        i_evt_valid,
    input wire [3:0]  i_evt_channel,
    input wire        i_evt_cfg_fetch,
    input wire [2:0]  i_evt_cycle_type,
    input wire        i_evt_task_done,
    input wire        i_evt_cycle_done,
    input wire        i_evt_bus_error,
    input wire [13:0] o_channel_enable,
    input wire [13:0] o_alt_select
);
    reg [3:0]  ch_reg;
    reg [13:0] alt_reg;
    always @(posedge i_clk) {ch_reg, alt_reg} <= {i_evt_channel, o_alt_select};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence ev(x); i_evt_valid && x && i_evt_channel < 4'd14; endsequence
    sequence flip; o_alt_select[ch_reg] != alt_reg[ch_reg]; endsequence
    done_off_a: assert property (ev(i_evt_cycle_done) |=> !o_channel_enable[ch_reg]) else $error("done");
    stop_off_a: assert property (ev(i_evt_cfg_fetch && i_evt_cycle_type == `DCEA_CYC_STOP)
        |=> !o_channel_enable[ch_reg]) else $error("stop");
    err_off_a: assert property (ev(i_evt_bus_error) |=> !o_channel_enable[ch_reg]) else $error("err");
    pp_flip_a: assert property (ev(i_evt_task_done && i_evt_cycle_type == `DCEA_CYC_PINGPONG)
        |=> flip) else $error("pp");
    sg_alt_flip_a: assert property (ev(i_evt_task_done && i_evt_cycle_type[0] && i_evt_cycle_type[2] && o_alt_select[i_evt_channel])
        |=> flip) else $error("sg");
    resv_zero_a: assert property (o_rvalid |-> o_rdata[31:14] == 18'h0) else $error("resv");
    rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("r");
    wr_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("b");
endmodule
bind dcea_channel_ctrl dcea_props u_props (.i_clk(i_clk), .i_reset(i_reset), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .o_bresp(o_bresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .i_evt_valid(i_evt_valid), .i_evt_channel(i_evt_channel), .i_evt_cfg_fetch(i_evt_cfg_fetch),
    .i_evt_cycle_type(i_evt_cycle_type), .i_evt_task_done(i_evt_task_done), .i_evt_cycle_done(i_evt_cycle_done),
    .i_evt_bus_error(i_evt_bus_error), .o_channel_enable(o_channel_enable), .o_alt_select(o_alt_select));

// file: dcea_engine_model.sv
`timescale 1ns/1ps
module dcea_engine_model (
    input  wire        i_clk,
    output reg  [11:0] o_evt = 12'h0
);
    // Valid, channel, cycle type, then fetch, task done, cycle done, bus error
    task send(input [3:0] ch, input [2:0] ty, input [3:0] kind);
        o_evt <= {1'b1, ch, ty, kind};
        @(posedge i_clk);
        // Fields turned over so a stale value never passes for a new one
        o_evt <= {1'b0, ~ch, ~ty, 4'h0};
        @(posedge i_clk);
    endtask
endmodule

// file: dcea_channel_enable_altselect_tb.sv
`timescale 1ns/1ps
`include "dcea_defines.vh"
module dcea_channel_enable_altselect_tb;
    localparam [11:0] a_en = `DCEA_OFF_ENABLE_SET, a_dis = `DCEA_OFF_DISABLE, a_alt = `DCEA_OFF_ALT_SELECT;
    localparam [11:0] a_pri = `DCEA_OFF_PRI_SELECT, a_sts = `DCEA_OFF_IRQ_STATUS, a_msk = `DCEA_OFF_IRQ_MASK;
    reg         clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    reg  [11:0] awa = 0, ara = 0;
    reg  [31:0] wd = 0;
    reg  [3:0]  stb = 4'hf;
    wire        awr, wrd, bv, arr, rvl, irq;
    wire [1:0]  br, rr;
    wire [31:0] rdat;
    wire [11:0] evt;
    wire [13:0] en, alt;
    integer     err_count = 0, comparisons = 0, cyc = 0, k;
    dcea_channel_ctrl dut (.i_clk(clk), .i_reset(rst), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
        .i_wdata(wd), .i_wstrb(stb), .i_wvalid(wv), .o_wready(wrd), .o_bresp(br), .o_bvalid(bv), .i_bready(bry),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rvl),
        .i_rready(rry), .i_evt_valid(evt[11]), .i_evt_channel(evt[10:7]), .i_evt_cycle_type(evt[6:4]),
        .i_evt_cfg_fetch(evt[3]), .i_evt_task_done(evt[2]), .i_evt_cycle_done(evt[1]),
        .i_evt_bus_error(evt[0]), .o_channel_enable(en), .o_alt_select(alt), .o_irq(irq));
    dcea_engine_model eng (.i_clk(clk), .o_evt(evt));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            conclude;
        end
    end
    task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task fin(input integer n); $display("test %0d done", n); endtask
    // Ready raised only after valid is seen, so the hold of each answer is exercised
    task bus(input w, input [11:0] a, input [31:0] d, input [1:0] er);
        {awa, ara, wd, awv, wv, arv} <= {a, a, d, w, w, !w};
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
            if (arr) arv <= 0;
        end while (!bv && !rvl);
        {bry, rry} <= {w, !w};
        @(posedge clk);
        {bry, rry} <= 2'b00;
        chk("resp", er, w ? br : rr);
        if (!w) chk("rdata", d, rdat);
    endtask
    task wr(input [11:0] a, input [31:0] d); bus(1, a, d, `DCEA_RESP_OKAY); endtask
    task rd(input [11:0] a, input [31:0] e); bus(0, a, e, `DCEA_RESP_OKAY); endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        rd(a_en, 0);
        bus(0, 12'h03c, 0, `DCEA_RESP_SLVERR);
        wr(a_en, 32'hffffffff);
        rd(a_en, 32'h3fff);
        wr(a_dis, 32'h5);
        wr(a_dis, 32'hffffc000);
        rd(a_en, 32'h3ffa);
        eng.send(5, `DCEA_CYC_PINGPONG, 4'h2);
        eng.send(6, `DCEA_CYC_STOP, 4'h8);
        eng.send(7, `DCEA_CYC_PINGPONG, 4'h1);
        eng.send(8, `DCEA_CYC_PINGPONG, 4'h8);
        eng.send(14, `DCEA_CYC_STOP, 4'hb);
        rd(a_en, 32'h3f1a);
        chk("en", 32'h3f1a, en);
        // Partial strobes are acknowledged but leave the channels alone
        stb <= 4'h1;
        wr(a_dis, 32'h3fff);
        stb <= 4'hf;
        rd(a_en, 32'h3f1a);
        fin(1);
        wr(a_alt, 32'hffff0003);
        wr(a_pri, 1);
        wr(a_alt, 0);
        rd(a_alt, 2);
        for (k = 0; k < 2; k++) begin
            eng.send(8, `DCEA_CYC_PINGPONG, 4'h4);
            rd(a_alt, k ? 2 : 32'h102);
        end
        // Channel 9 runs memory, channel 10 peripheral scatter-gather
        for (k = 9; k < 11; k++) begin
            repeat (`DCEA_SG_PRI_XFERS - 1) eng.send(k, 2 * k - 14, 4'h4);
            rd(a_alt, 2);
            eng.send(k, 2 * k - 14, 4'h4);
            rd(a_alt, 32'h2 | 1 << k);
            chk("alt", 32'h2 | 1 << k, alt);
            eng.send(k, 2 * k - 13, 4'h4);
            rd(a_alt, 2);
        end
        fin(2);
        chk("irq", 0, irq);
        wr(a_msk, 7);
        chk("irq", 1, irq);
        rd(a_sts, 7);
        rd(a_sts, 0);
        chk("irq", 0, irq);
        eng.send(14, `DCEA_CYC_STOP, 4'hb);
        chk("irq", 0, irq);
        rd(a_sts, 0);
        wr(a_msk, 4);
        eng.send(9, `DCEA_CYC_PINGPONG, 4'h2);
        chk("irq", 0, irq);
        eng.send(9, `DCEA_CYC_PINGPONG, 4'h1);
        chk("irq", 1, irq);
        rd(a_sts, 5);
        fin(3);
        conclude;
    end
endmodule
